// ===== logic/cci_chan.v
`include "cci_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module cci_chan (
   // Clock and reset
   input  wire clk_sys,
   input  wire rstn,
   // Control
   input  wire enable,
   input  wire flag_clr,
   // Analog core result, high while positive input exceeds negative input
   input  wire cmp_raw,
   // Status
   output wire result,
   output wire change_flag,
   output wire settling
);

   reg                       sync1_ff;
   reg                       sync2_ff;
   reg                       prev_ff;
   reg                       en_d_ff;
   reg                       flag_ff;
   reg  [`CCI_SETTLE_W-1:0]  settle_ff;
   reg  [`CCI_SETTLE_W-1:0]  nxt_settle;
   wire                      change;

   always @* begin
      nxt_settle = settle_ff;
      if (!enable) begin
         nxt_settle = {`CCI_SETTLE_W{1'b0}};
      // R06 settle window
      end else if (!en_d_ff) begin
         nxt_settle = `CCI_SETTLE_CYC;
      end else if (settle_ff != {`CCI_SETTLE_W{1'b0}}) begin
         nxt_settle = settle_ff - {{(`CCI_SETTLE_W-1){1'b0}}, 1'b1};
      end
   end

   // R10 either edge
   // The first enabled cycle still sees the count at zero before it loads, so it is blocked too.
   assign change = enable && en_d_ff && (settle_ff == {`CCI_SETTLE_W{1'b0}}) &&
                   (sync2_ff != prev_ff);

   always @(posedge clk_sys) begin
      if (!rstn) begin
         sync1_ff  <= 1'b0;
         sync2_ff  <= 1'b0;
         prev_ff   <= 1'b0;
         en_d_ff   <= 1'b0;
         flag_ff   <= 1'b0;
         settle_ff <= {`CCI_SETTLE_W{1'b0}};
      end else begin
         sync1_ff  <= cmp_raw;
         sync2_ff  <= sync1_ff;
         prev_ff   <= sync2_ff;
         en_d_ff   <= enable;
         settle_ff <= nxt_settle;
         // R05 flag sets, set beats clear
         flag_ff   <= change | (flag_ff & ~flag_clr);
      end
   end

   // R01 result zero unless enabled and positive input higher
   assign result      = enable & sync2_ff;
   assign change_flag = flag_ff;
   assign settling    = (settle_ff != {`CCI_SETTLE_W{1'b0}});

endmodule

// ===== logic/cci_defs.vh
`ifndef CCI_DEFS_VH
`define CCI_DEFS_VH

// Register byte addresses on the AXI4-Lite port.
`define CCI_OFF_CTRL0        4'h0
`define CCI_OFF_CTRL1        4'h4
`define CCI_OFF_STATUS       4'h8
`define CCI_OFF_MASK         4'hc

// Fields of each comparator_control register.
`define CCI_CTRL_EN          0
`define CCI_CTRL_REF_SEL     1
`define CCI_CTRL_PIN_EN      2
`define CCI_CTRL_OUT_VAL     4
`define CCI_CTRL_SETTLING    5
`define CCI_CTRL_WR_MASK     3'h7
`define CCI_CTRL_RST         3'h0

// Status and mask layout: one change flag per comparator in bits 1:0.
`define CCI_STAT_FLAG_LSB    0
`define CCI_MASK_RST         2'h0

// AXI response codes.
`define CCI_RESP_OKAY        2'h0
`define CCI_RESP_SLVERR      2'h2

// Settling window after enable.
`define CCI_SETTLE_NS        10000
`define CCI_CLK_PERIOD_NS    4
// Settle count is the settle time over the clock period, sized to the settle counter.
`define CCI_SETTLE_CYC       12'd2500
`define CCI_SETTLE_W         12

`endif

// ===== logic/cci_top.v
`include "cci_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// R01 - Comparator result is one only while positive input exceeds negative input.
// R02 - Each comparator's negative input selects between pin and internal reference.
// R03 - Software reads the current comparator output as a register bit.
// R04 - On the pin-capable variant, comparator output may drive an output pin.
// R05 - When configured, an output change sets the flag and requests an interrupt.
// R06 - After enable, output and flag are unreliable for a 10 us settling time.
// R07 - Software keeps the interrupt disabled during the settling time.
// R08 - Software clears the flag before enabling the interrupt.
// R09 - One comparator on the small variant, two otherwise, each with own control.
// R10 - Flag sets on either edge of the synced output and stays until cleared.
module cci_top #(
   parameter CMP_COUNT   = 2,
   parameter PIN_VARIANT = 1
) (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        rstn,
   // AXI4-Lite write address
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Analog comparator cores
   input  wire [1:0]  cmp_raw,
   output wire [1:0]  cmp_enable,
   output wire [1:0]  cmp_ref_sel,
   // Comparator output pins
   output wire [1:0]  cmp_pin_o,
   output wire [1:0]  cmp_pin_oe,
   // Interrupt
   output wire        irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   reg         awready_ff;
   reg         wready_ff;
   reg         bvalid_ff;
   reg  [1:0]  bresp_ff;
   reg         arready_ff;
   reg         rvalid_ff;
   reg  [1:0]  rresp_ff;
   reg  [31:0] rdata_ff;
   reg         aw_hold_ff;
   reg         w_hold_ff;
   reg  [3:0]  awaddr_ff;
   reg  [31:0] wdata_ff;
   reg  [3:0]  wstrb_ff;

   reg  [2:0]  ctrl_ff [0:1];
   reg  [1:0]  mask_ff;
   reg         irq_ff;
   reg  [1:0]  pin_o_ff;
   reg  [1:0]  pin_oe_ff;
   reg  [1:0]  en_ff;
   reg  [1:0]  ref_ff;

   reg  [31:0] nxt_rdata;
   reg  [1:0]  nxt_rresp;
   reg  [1:0]  nxt_bresp;
   reg         nxt_stat_rd;

   wire        aw_take;
   wire        w_take;
   wire        ar_take;
   wire        do_write;
   wire [3:0]  araddr_w;
   wire [1:0]  result;
   wire [1:0]  flag;
   wire [1:0]  settling;
   wire [1:0]  flag_clr;
   wire [1:0]  present;

   assign aw_take  = s_axi_awvalid & awready_ff;
   assign w_take   = s_axi_wvalid & wready_ff;
   assign ar_take  = s_axi_arvalid & arready_ff;
   assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
   assign araddr_w = s_axi_araddr[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // Comparator channels

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
         // R09 channel count
         assign present[gi] = (gi < CMP_COUNT);

         cci_chan u_chan (
            .clk_sys     (clk_sys),
            .rstn        (rstn),
            .enable      (ctrl_ff[gi][`CCI_CTRL_EN] & present[gi]),
            .flag_clr    (flag_clr[gi]),
            .cmp_raw     (cmp_raw[gi]),
            .result      (result[gi]),
            .change_flag (flag[gi]),
            .settling    (settling[gi])
         );
      end
   endgenerate

   // A status read clears the flags it returned; the channel lets a new edge win.
   assign flag_clr = {2{ar_take & nxt_stat_rd}};

   ////////////////////////////////////////////////////////////////////////////
   // Write channel

   always @* begin
      nxt_bresp = `CCI_RESP_OKAY;
      case (awaddr_ff)
         `CCI_OFF_CTRL0:  nxt_bresp = `CCI_RESP_OKAY;
         `CCI_OFF_CTRL1:  nxt_bresp = present[1] ? `CCI_RESP_OKAY : `CCI_RESP_SLVERR;
         `CCI_OFF_STATUS: nxt_bresp = `CCI_RESP_OKAY;
         `CCI_OFF_MASK:   nxt_bresp = `CCI_RESP_OKAY;
         default:         nxt_bresp = `CCI_RESP_SLVERR;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `CCI_RESP_OKAY;
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awaddr_ff  <= 4'h0;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
      end else begin
         if (aw_take) begin
            awaddr_ff  <= s_axi_awaddr[3:0];
            aw_hold_ff <= 1'b1;
            awready_ff <= 1'b0;
         end
         if (w_take) begin
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
            w_hold_ff <= 1'b1;
            wready_ff <= 1'b0;
         end
         if (do_write) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= nxt_bresp;
         end
         // Address and data are only offered again once the response is taken.
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and mask registers

   always @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_ff[0] <= `CCI_CTRL_RST;
         ctrl_ff[1] <= `CCI_CTRL_RST;
         mask_ff    <= `CCI_MASK_RST;
      end else if (do_write && wstrb_ff[0]) begin
         case (awaddr_ff)
            `CCI_OFF_CTRL0: ctrl_ff[0] <= wdata_ff[2:0] & `CCI_CTRL_WR_MASK;
            `CCI_OFF_CTRL1: begin
               if (present[1]) begin
                  ctrl_ff[1] <= wdata_ff[2:0] & `CCI_CTRL_WR_MASK;
               end
            end
            `CCI_OFF_MASK:  mask_ff <= wdata_ff[1:0] & present;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel

   always @* begin
      nxt_rdata   = 32'h0000_0000;
      nxt_rresp   = `CCI_RESP_OKAY;
      nxt_stat_rd = 1'b0;
      case (araddr_w)
         `CCI_OFF_CTRL0: begin
            nxt_rdata[2:0] = ctrl_ff[0];
            // R03 output readback
            nxt_rdata[`CCI_CTRL_OUT_VAL]  = result[0];
            nxt_rdata[`CCI_CTRL_SETTLING] = settling[0];
         end
         `CCI_OFF_CTRL1: begin
            if (present[1]) begin
               nxt_rdata[2:0] = ctrl_ff[1];
               nxt_rdata[`CCI_CTRL_OUT_VAL]  = result[1];
               nxt_rdata[`CCI_CTRL_SETTLING] = settling[1];
            end else begin
               nxt_rresp = `CCI_RESP_SLVERR;
            end
         end
         `CCI_OFF_STATUS: begin
            nxt_rdata[1:0] = flag & present;
            nxt_stat_rd    = 1'b1;
         end
         `CCI_OFF_MASK: begin
            nxt_rdata[1:0] = mask_ff;
         end
         default: begin
            nxt_rresp = `CCI_RESP_SLVERR;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= `CCI_RESP_OKAY;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rresp_ff   <= nxt_rresp;
            rdata_ff   <= nxt_rdata;
         end
         if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog controls, pin routing and interrupt

   integer k;
   always @(posedge clk_sys) begin
      if (!rstn) begin
         en_ff     <= 2'h0;
         ref_ff    <= 2'h0;
         pin_o_ff  <= 2'h0;
         pin_oe_ff <= 2'h0;
         irq_ff    <= 1'b0;
      end else begin
         for (k = 0; k < 2; k = k + 1) begin
            en_ff[k]     <= ctrl_ff[k][`CCI_CTRL_EN] & present[k];
            // R02 reference select
            ref_ff[k]    <= ctrl_ff[k][`CCI_CTRL_REF_SEL] & present[k];
            // R04 pin routing
            pin_oe_ff[k] <= ctrl_ff[k][`CCI_CTRL_PIN_EN] & present[k] & (PIN_VARIANT != 0);
            pin_o_ff[k]  <= result[k] & ctrl_ff[k][`CCI_CTRL_PIN_EN] & (PIN_VARIANT != 0);
         end
         // R05 interrupt request
         irq_ff <= |(flag & mask_ff & present);
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign cmp_enable    = en_ff;
   assign cmp_ref_sel   = ref_ff;
   assign cmp_pin_o     = pin_o_ff;
   assign cmp_pin_oe    = pin_oe_ff;
   assign irq           = irq_ff;

endmodule

// ===== test/cci_cmp_model.sv
module cci_cmp_model #(
   parameter logic [11:0] REF_MV = 12'h4d0
) (
   // Clock and stimulus
   input  logic             clk_sys,
   input  logic [1:0][11:0] pos_mv,
   input  logic [1:0][11:0] pin_mv,
   // Control from the block
   input  logic [1:0]       cmp_enable,
   input  logic [1:0]       cmp_ref_sel,
   // Results
   output logic [1:0]       cmp_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idle_ff = 1'b0;
   always @(posedge clk_sys) idle_ff <= ~idle_ff;
   // A powered-down core gives no valid answer, so it toggles instead of holding a level.
   always_comb begin
      for (int n = 0; n < 2; n++) begin
         cmp_raw[n] = cmp_enable[n] ? pos_mv[n] > (cmp_ref_sel[n] ? REF_MV : pin_mv[n]) : idle_ff;
      end
   end
endmodule

// ===== test/cci_top_assertions.sv
module cci_checker (
   // Clock and reset
   input logic        clk_sys,
   input logic        rstn,
   // Register bus
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   // Comparator side
   input logic [1:0]  cmp_enable,
   input logic [1:0]  cmp_pin_o,
   input logic [1:0]  cmp_pin_oe,
   input logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wr_answer_a:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
   rd_answer_a:
   assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer missing");
   wr_refused_a:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   rd_refused_a:
   assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
   wr_single_a:
   assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("double write answer");
   rd_single_a:
   assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("double read answer");
   rd_upper_a:
   assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0) else $error("upper read bits set");
   reset_quiet_a:
   assert property ($rose(rstn) |-> !irq && cmp_enable == 2'h0 && s_axi_arready)
      else $error("outputs not at reset values");
   pin_gated_a:
   assert property ((cmp_pin_o & ~cmp_pin_oe) == 2'h0) else $error("pin driven while not enabled");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property ($rose(irq));
   cover property ($fell(irq));
endmodule

bind cci_top cci_checker chk_u (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .cmp_enable, .cmp_pin_o, .cmp_pin_oe, .irq);

// ===== test/test_comparator_change_interrupt.sv
`include "cci_defs.vh"
module test_comparator_change_interrupt;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] REF_MV = 12'h4d0;
   localparam logic [1:0]  RSEL = 2'b01;
   logic clk_sys = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, irq;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, cmp_raw, cmp_enable, cmp_ref_sel;
   logic [1:0]  cmp_pin_o, cmp_pin_oe, prev, chg, mask;
   logic [1:0][11:0] pos_mv = 0, pin_mv = 0;
   logic [1:0]  bresp1, enable1, ref_sel1, pin_oe1;
   logic        irq1;
   int seed = 32'h55bd;
   int err_total = 0;
   int checked = 0;
   int n;

   initial forever #2 clk_sys = ~clk_sys;

   cci_top #(.CMP_COUNT(2), .PIN_VARIANT(1)) dut_u (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw, .cmp_enable, .cmp_ref_sel,
      .cmp_pin_o, .cmp_pin_oe, .irq);
   // A one-comparator variant without pin routing shares the bus and sees every transfer.
   cci_top #(.CMP_COUNT(1), .PIN_VARIANT(0)) dut1_u (.clk_sys, .rstn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready(), .s_axi_bresp(bresp1), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready, .cmp_raw, .cmp_enable(enable1), .cmp_ref_sel(ref_sel1), .cmp_pin_o(),
      .cmp_pin_oe(pin_oe1), .irq(irq1));
   cci_cmp_model #(.REF_MV(REF_MV)) model_u (.clk_sys, .pos_mv, .pin_mv, .cmp_enable,
      .cmp_ref_sel, .cmp_raw);

   ////////////////////////////////////////
   function automatic logic [1:0] exp_res();
      for (int k = 0; k < 2; k++) exp_res[k] = pos_mv[k] > (RSEL[k] ? REF_MV : pin_mv[k]);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         if (s_axi_awready && !aw_ok) begin
            aw_ok = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wready && !w_ok) begin
            w_ok = 1;
            s_axi_wvalid <= 0;
         end
      end
      do @(posedge clk_sys); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge clk_sys);
   endtask

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      @(posedge clk_sys);
   endtask

   ////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict;
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1;
      @(posedge clk_sys);
      // Only address bits 3:0 are decoded, so a misaligned offset stands for an unmapped one.
      for (int a = 0; a < 5; a++) begin
         axi_rd(a < 4 ? a * 4 : 32'h6, rd, rsp);
         if (a < 4) chk(rd, 0);
         chk(rsp, a == 4 ? `CCI_RESP_SLVERR : `CCI_RESP_OKAY);
      end
      axi_wr(`CCI_OFF_CTRL0, 32'h7, 4'h0, rsp);
      axi_wr(32'h6, 32'h7, 4'hf, rsp);
      chk({rsp, cmp_enable}, {`CCI_RESP_SLVERR, 2'h0});
      $display("test reset and refusals done");
      axi_wr(`CCI_OFF_CTRL0, 32'h7, 4'hf, rsp);
      axi_wr(`CCI_OFF_CTRL1, 32'h5, 4'hf, rsp);
      chk({cmp_pin_oe, cmp_ref_sel, cmp_enable}, {2'b11, RSEL, 2'b11});
      chk({bresp1, pin_oe1, ref_sel1, enable1}, {`CCI_RESP_SLVERR, 6'b00_01_01});
      // Results flip while settling; none of these changes may leave a flag.
      for (int i = 0; i < 4; i++) begin
         pos_mv <= {2{i[0] ? 12'hfff : 12'h000}};
         repeat (6) @(posedge clk_sys);
         axi_rd(`CCI_OFF_CTRL0, rd, rsp);
         chk(rd[5:4], {1'b1, i[0]});
      end
      repeat (`CCI_SETTLE_CYC) @(posedge clk_sys);
      axi_rd(`CCI_OFF_CTRL1, rd, rsp);
      chk(rd[5], 0);
      axi_rd(`CCI_OFF_STATUS, rd, rsp);
      chk(rd, 0);
      mask = 2'b11;
      axi_wr(`CCI_OFF_MASK, 32'h3, 4'hf, rsp);
      $display("test settling done");
      prev = exp_res();
      for (int i = 0; i < 40; i++) begin
         n = $random(seed) & 1;
         if (i % 8 == 0) begin
            pos_mv[n] <= RSEL[n] ? REF_MV : pin_mv[n];
         end else begin
            pos_mv[n] <= 12'($random(seed));
            pin_mv[n] <= 12'($random(seed));
         end
         if (i == 20) begin
            mask = 2'b00;
            axi_wr(`CCI_OFF_MASK, 32'h0, 4'hf, rsp);
         end
         repeat (6) @(posedge clk_sys);
         chg = prev ^ exp_res();
         prev = exp_res();
         axi_rd(n * 4, rd, rsp);
         chk(rd[4], prev[n]);
         chk(cmp_pin_o[n], prev[n]);
         chk({irq, irq1}, {|(chg & mask), chg[0] & mask[0]});
         axi_rd(`CCI_OFF_STATUS, rd, rsp);
         chk(rd, {30'h0, chg});
         chk({irq, irq1}, 0);
      end
      $display("test change flags done");
      axi_wr(`CCI_OFF_CTRL0, 32'h0, 4'hf, rsp);
      axi_rd(`CCI_OFF_CTRL0, rd, rsp);
      chk({rd[4], cmp_enable[0], cmp_pin_oe[0]}, 0);
      $display("test disable done");
      give_verdict;
   end
endmodule
